// file: design/cnc_axis_status.sv
/*
  axis status and safety signals with a wishbone register slave.
  assumes limit, emergency stop and drive inputs are asynchronous pins; motion
  requests come from logic on clk_i.
*/
`timescale 1ns/1ps
`include "cnc_status_defines.svh"
module cnc_axis_status #(
  parameter int DECEL = `DECEL_CYCLES,
  parameter logic [4:0] BRAKE_MASK = `BRAKE_MASK_DEF,
  parameter logic LIMIT_ACTIVE = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic emergency_stop_input_i,
  input wire logic [4:0] positive_limit_inputs_i,
  input wire logic [4:0] negative_limit_inputs_i,
  input wire logic drives_ready_i,
  input wire logic servo_alarm_i,
  // motion requests
  input wire logic [4:0] axis_run_i,
  input wire logic [4:0] axis_dir_i,
  // status
  output logic [4:0] axis_moving_flags_o,
  output logic [4:0] axis_direction_flags_o,
  output logic servo_ready_o,
  output logic [4:0] brake_release_o,
  output logic fault_flag_o,
  output logic ctrl_reset_o
);
  // two-flop synchronisers
  logic [12:0] meta;
  logic [12:0] sync;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 13'h0000;
      sync <= 13'h0000;
    end else begin
      meta <= {servo_alarm_i, drives_ready_i, emergency_stop_input_i,
               negative_limit_inputs_i, positive_limit_inputs_i}; // R13 R07
      sync <= meta;
    end
  end
  wire logic [4:0] pos_hit = sync[4:0] ^ {5{~LIMIT_ACTIVE}};
  wire logic [4:0] neg_hit = sync[9:5] ^ {5{~LIMIT_ACTIVE}};
  wire logic estop_s = sync[10];
  wire logic drives_ready_s = sync[11];
  wire logic servo_alarm_s = sync[12];

  // control register and bus decode
  logic auto_mode;
  logic [4:0] lock_pos;
  logic [4:0] lock_neg;
  wire logic req = cyc_i & stb_i & ~ack_o;
  wire logic wr_ctrl = req & we_i & sel_i[0] & (adr_i == `ADR_CONTROL);
  wire logic sw_reset = wr_ctrl & dat_i[`BIT_CTRL_RESET];
  wire logic prog_alarm = wr_ctrl & dat_i[`BIT_PROG_ALARM];
  wire logic ctrl_reset = sw_reset | estop_s; // R06
  wire logic any_lock = |{lock_pos, lock_neg};
  wire logic [4:0] decel = {5{auto_mode & any_lock}}; // R08
  wire logic ot_event = |{pos_hit, neg_hit};
  wire logic fault_set = ot_event | servo_alarm_s | prog_alarm; // R11
  wire logic next_servo_ready = drives_ready_s & ~estop_s; // R04

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `RST_WORD;
    unique case (adr_i)
      `ADR_SERVO_READY: rd_mux[`BIT_SERVO_READY] = servo_ready_o;
      `ADR_FAULT: rd_mux[`BIT_FAULT] = fault_flag_o;
      `ADR_MOTION: rd_mux[4:0] = axis_moving_flags_o;
      `ADR_DIRECTION: rd_mux[4:0] = axis_direction_flags_o;
      `ADR_CONTROL: rd_mux[`BIT_AUTO_MODE] = auto_mode;
      `ADR_LOCKOUT: rd_mux[`LOCK_NEG_LSB +: 5] = lock_neg;
      default: rd_mux = `RST_WORD;
    endcase
    if (adr_i == `ADR_LOCKOUT) rd_mux[4:0] = lock_pos;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `RST_WORD;
      auto_mode <= 1'b0;
    end else begin
      ack_o <= req;
      if (req) dat_o <= rd_mux;
      if (wr_ctrl) auto_mode <= dat_i[`BIT_AUTO_MODE];
    end
  end

  // lockout and fault: a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_pos <= `RST_AXES;
      lock_neg <= `RST_AXES;
      fault_flag_o <= 1'b0;
    end else begin
      lock_pos <= (ctrl_reset ? `RST_AXES : lock_pos) | pos_hit; // R10
      lock_neg <= (ctrl_reset ? `RST_AXES : lock_neg) | neg_hit; // R10
      fault_flag_o <= (fault_flag_o & ~ctrl_reset) | fault_set; // R11 R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_ready_o <= 1'b0;
      brake_release_o <= `RST_AXES;
      ctrl_reset_o <= 1'b0;
    end else begin
      servo_ready_o <= next_servo_ready;
      brake_release_o <= next_servo_ready ? BRAKE_MASK : `RST_AXES; // R05
      ctrl_reset_o <= ctrl_reset; // R06
    end
  end

  // per-axis channels
  for (genvar i = 0; i < `AXES; i++) begin : g_axis
    axis_channel #(
      .DECEL(DECEL)
    ) u_axis (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(axis_run_i[i]),
      .dir_i(axis_dir_i[i]),
      .halt_i(estop_s), // R06
      .decel_i(decel[i]), // R08
      .lock_pos_i(lock_pos[i]), // R09
      .lock_neg_i(lock_neg[i]), // R09
      .moving_o(axis_moving_flags_o[i]),
      .dir_o(axis_direction_flags_o[i])
    );
  end

  // checks
  estop_halt_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    estop_s |=> axis_moving_flags_o == `RST_AXES)
    else $error("axis still moving after emergency stop");

  estop_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    estop_s |=> ctrl_reset_o && !servo_ready_o)
    else $error("emergency stop did not reset");

  fault_raise_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ot_event || servo_alarm_s |=> fault_flag_o)
    else $error("alarm not raised");

  fault_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    fault_flag_o && !ctrl_reset |=> fault_flag_o)
    else $error("fault flag dropped without reset");

  lock_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    !ctrl_reset |=> ({lock_pos, lock_neg} & $past({lock_pos, lock_neg}))
      == $past({lock_pos, lock_neg}))
    else $error("overtravel lockout lost");

  servo_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    !drives_ready_s |=> !servo_ready_o)
    else $error("servo ready without drives");

  brake_link_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    brake_release_o == (servo_ready_o ? BRAKE_MASK : `RST_AXES))
    else $error("brake state disagrees with servo ready");

  dir_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    ((~axis_moving_flags_o & ~$past(axis_moving_flags_o))
     & (axis_direction_flags_o ^ $past(axis_direction_flags_o))) == `RST_AXES)
    else $error("direction changed while stopped");

  auto_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    auto_mode && any_lock |=> (axis_moving_flags_o & ~$past(axis_moving_flags_o)) == `RST_AXES)
    else $error("axis started during automatic overtravel");

  lock_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (axis_moving_flags_o & ~$past(axis_moving_flags_o)
     & ((axis_direction_flags_o & $past(lock_pos))
        | (~axis_direction_flags_o & $past(lock_neg)))) == `RST_AXES)
    else $error("axis started into locked direction");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o)
    else $error("wishbone ack not one cycle");

  estop_c: cover property (@(posedge clk_i) disable iff (rst_i)
    |axis_moving_flags_o ##1 estop_s);
  overtravel_c: cover property (@(posedge clk_i) disable iff (rst_i)
    auto_mode && ot_event && |axis_moving_flags_o);
  manual_ot_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !auto_mode && any_lock && |axis_moving_flags_o);
  bus_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_i == `ADR_FAULT);
endmodule : cnc_axis_status

// file: design/cnc_status_defines.svh
/*
  constants for the axis status and safety block: register offsets, field positions,
  reset values and timing counts.
  assumes a 100 MHz clock and a 32-bit classic wishbone bus with byte addresses.
*/
// Function
// R01 - moving flag high while axis moves
// R02 - direction flag one for positive travel
// R03 - direction flag holds last value when stopped
// R04 - servo ready only after drives ready
// R05 - brake released only while servo ready
// R06 - emergency stop halts, resets, stays stopped
// R07 - limit inputs per axis and direction
// R08 - automatic overtravel decelerates all, alarms, stops
// R09 - manual overtravel stops only offending axis
// R10 - offending direction locked until alarm cleared
// R11 - fault flag high in any alarm
// R12 - fault flag cleared only by controller reset
// R13 - inputs sampled and flags updated on one clock
`ifndef CNC_STATUS_DEFINES_SVH
`define CNC_STATUS_DEFINES_SVH

`define AXES 5
`define CLK_PERIOD_NS 10
`define DECEL_TIME_NS 1000
`define DECEL_CYCLES (`DECEL_TIME_NS / `CLK_PERIOD_NS)

`define ADR_SERVO_READY 8'h00
`define ADR_FAULT 8'h04
`define ADR_MOTION 8'h08
`define ADR_DIRECTION 8'h0c
`define ADR_CONTROL 8'h10
`define ADR_LOCKOUT 8'h14

`define BIT_SERVO_READY 6
`define BIT_FAULT 0
`define BIT_AUTO_MODE 0
`define BIT_CTRL_RESET 1
`define BIT_PROG_ALARM 2
`define LOCK_NEG_LSB 8

`define RST_AXES 5'h00
`define RST_WORD 32'h0000_0000
`define BRAKE_MASK_DEF 5'h1f
`endif

// file: design/cnc_status_pkg.sv
/*
  types shared by the axis status block.
  assumes nothing beyond a systemverilog compiler.
*/
package cnc_status_pkg;
  typedef enum logic [1:0] {
    AXIS_IDLE,
    AXIS_RUN,
    AXIS_DECEL
  } axis_state_t;
endpackage : cnc_status_pkg

// file: design/axis_channel.sv
/*
  one axis: moving and direction flags, deceleration and direction lockout.
  assumes all inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "cnc_status_defines.svh"
module axis_channel #(
  parameter int DECEL = `DECEL_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // motion request
  input wire logic run_i,
  input wire logic dir_i,
  // safety
  input wire logic halt_i,
  input wire logic decel_i,
  input wire logic lock_pos_i,
  input wire logic lock_neg_i,
  // status
  output logic moving_o,
  output logic dir_o
);
  cnc_status_pkg::axis_state_t state;
  cnc_status_pkg::axis_state_t next_state;
  logic [15:0] count;
  wire logic locked_req = dir_i ? lock_pos_i : lock_neg_i;
  wire logic locked_cur = dir_o ? lock_pos_i : lock_neg_i;
  wire logic start = run_i & ~halt_i & ~decel_i & ~locked_req;
  wire logic slow = decel_i | ~run_i | locked_cur;

  always_comb begin
    next_state = state;
    unique case (state)
      cnc_status_pkg::AXIS_IDLE: if (start) next_state = cnc_status_pkg::AXIS_RUN;
      cnc_status_pkg::AXIS_RUN: begin
        if (halt_i) next_state = cnc_status_pkg::AXIS_IDLE;
        else if (slow) next_state = cnc_status_pkg::AXIS_DECEL;
      end
      cnc_status_pkg::AXIS_DECEL: begin
        if (halt_i || count == 16'h0000) next_state = cnc_status_pkg::AXIS_IDLE;
      end
      default: next_state = cnc_status_pkg::AXIS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= cnc_status_pkg::AXIS_IDLE;
      count <= 16'h0000;
      moving_o <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      state <= next_state;
      moving_o <= next_state != cnc_status_pkg::AXIS_IDLE; // R01
      if (state == cnc_status_pkg::AXIS_IDLE && start) dir_o <= dir_i; // R02 R03
      if (next_state == cnc_status_pkg::AXIS_DECEL && state != cnc_status_pkg::AXIS_DECEL)
        count <= 16'(DECEL - 1);
      else if (count != 16'h0000) count <= count - 16'h0001;
    end
  end
endmodule : axis_channel

// file: tb/plc_model.sv
/*
  ladder-logic side: estop and stroke-limit pins driven from bench commands.
  assumes commands change right after a rising clock edge.
*/
`timescale 1ns/1ps
module plc_model (
  // commands
  input wire logic estop_cmd_i,
  input wire logic [4:0] pos_cmd_i,
  input wire logic [4:0] neg_cmd_i,
  // pins
  output logic emergency_stop_input_o,
  output logic [4:0] positive_limit_inputs_o,
  output logic [4:0] negative_limit_inputs_o
);
  assign emergency_stop_input_o = estop_cmd_i;
  assign positive_limit_inputs_o = pos_cmd_i;
  assign negative_limit_inputs_o = neg_cmd_i;
endmodule : plc_model

// file: tb/cnc_axis_status_tb.sv
/*
  self-checking bench for the axis status block.
  assumes the plc model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module cnc_axis_status_tb;
  localparam int DEC = 4;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, drv = 0, salm = 0, esc = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, q, dat_o;
  logic [4:0] run = 0, dir = 0, pc = 0, nc = 0, e_dr = 0, mv, dr, brk, pl, nl;
  logic ack, srv, flt, crst, es;
  int n_fail = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  plc_model plc_model_inst (.estop_cmd_i(esc), .pos_cmd_i(pc), .neg_cmd_i(nc),
    .emergency_stop_input_o(es), .positive_limit_inputs_o(pl), .negative_limit_inputs_o(nl));
  cnc_axis_status #(.DECEL(DEC)) cnc_axis_status_inst (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(dat), .sel_i(4'hf), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .dat_o(dat_o), .ack_o(ack), .emergency_stop_input_i(es), .positive_limit_inputs_i(pl),
    .negative_limit_inputs_i(nl), .drives_ready_i(drv), .servo_alarm_i(salm),
    .axis_run_i(run), .axis_dir_i(dir), .axis_moving_flags_o(mv),
    .axis_direction_flags_o(dr), .servo_ready_o(srv), .brake_release_o(brk),
    .fault_flag_o(flt), .ctrl_reset_o(crst));
  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  // one classic cycle, entered right after an edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      complete_run();
    end
    @(posedge clk_i);
  endtask : wb
  initial begin
    logic [31:0] r;
    void'($urandom(69555));
    step(5);
    rst_i <= 1'b0;
    step(1);
    chk({mv, dr, brk, srv, flt}, 32'h0000_0000);
    drv <= 1'b1;
    step(4);
    chk(srv, 1'b1);
    chk(brk, 5'h1f);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_0040);
    drv <= 1'b0;
    step(4);
    chk({srv, brk}, 32'h0000_0000);
    drv <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      run <= r[4:0];
      dir <= r[9:5];
      e_dr = (e_dr & ~r[4:0]) | (r[9:5] & r[4:0]);
      step(2);
      chk(mv, r[4:0]);
      chk(dr, e_dr);
      wb(1'b0, 8'h08, 32'h0000_0000);
      chk(q, {27'h0, r[4:0]});
      wb(1'b0, 8'h0c, 32'h0000_0000);
      chk(q, {27'h0, e_dr});
      run <= 5'h00;
      step(DEC + 4);
      chk(mv, 5'h00);
      chk(dr, e_dr);
    end
    // manual overtravel on axis 0 positive
    run <= 5'h03;
    dir <= 5'h01;
    step(2);
    pc <= 5'h01;
    step(4);
    chk(flt, 1'b1);
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    step(DEC);
    chk(mv, 5'h02);
    pc <= 5'h00;
    step(4);
    chk(mv, 5'h02);
    dir <= 5'h00;
    step(2);
    chk(mv, 5'h03);
    chk(dr, e_dr & 5'h1c);
    run <= 5'h00;
    step(DEC + 4);
    wb(1'b1, 8'h10, 32'h0000_0002);
    step(1);
    chk(flt, 1'b0);
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // automatic overtravel on axis 2 negative
    wb(1'b1, 8'h10, 32'h0000_0001);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    run <= 5'h1f;
    step(2);
    nc <= 5'h04;
    step(4);
    chk(flt, 1'b1);
    step(DEC + 1);
    chk(mv, 5'h00);
    nc <= 5'h00;
    run <= 5'h00;
    step(4);
    wb(1'b1, 8'h10, 32'h0000_0002);
    step(1);
    chk(flt, 1'b0);
    salm <= 1'b1;
    step(4);
    chk(flt, 1'b1);
    salm <= 1'b0;
    step(3);
    wb(1'b1, 8'h10, 32'h0000_0002);
    step(1);
    chk(flt, 1'b0);
    wb(1'b1, 8'h10, 32'h0000_0004);
    step(1);
    chk(flt, 1'b1);
    run <= 5'h1f;
    step(2);
    esc <= 1'b1;
    step(5);
    chk(mv, 5'h00);
    chk(crst, 1'b1);
    chk(flt, 1'b0);
    esc <= 1'b0;
    run <= 5'h00;
    step(5);
    chk(crst, 1'b0);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    complete_run();
  end
endmodule : cnc_axis_status_tb
